// file: inc/ccs_pkg.sv
package ccs_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] OFS_CLOCK_MODE_SELECT = 8'h00;
   localparam logic [7:0] OFS_MAIN_OSC_CTRL     = 8'h01;
   localparam logic [7:0] OFS_MAIN_CLOCK_MODE   = 8'h02;
   localparam logic [7:0] OFS_PROCESSOR_CLOCK   = 8'h03;
   localparam logic [7:0] OFS_INTERNAL_OSC_MODE = 8'h04;
   localparam logic [7:0] OFS_PORT_FUNCTION     = 8'h05;
   localparam logic [7:0] OFS_OSC_STAB_STATUS   = 8'h06;

   // Field positions
   localparam int BIT_MAIN_EXT_CLK_SEL  = 7;
   localparam int BIT_MAIN_OSC_MODE     = 6;
   localparam int BIT_SUB_EXT_CLK_SEL   = 5;
   localparam int BIT_SUB_OSC_MODE      = 4;
   localparam int BIT_MAIN_OSC_STOP     = 7;
   localparam int BIT_MAIN_CLK_RANGE    = 2;
   localparam int BIT_MAIN_CLK_STATUS   = 1;
   localparam int BIT_MAIN_CLK_SEL      = 0;
   localparam int BIT_CPU_SUB_STATUS    = 5;
   localparam int BIT_CPU_SUB_SEL       = 4;
   localparam int BIT_INT_HS_OSC_STATUS = 7;
   localparam int BIT_INT_HS_OSC_STOP   = 0;
   localparam int BIT_SUB_EXT_SEL       = 1;
   localparam int BIT_SUB_PIN_OUT_EN    = 0;
   localparam int BIT_MAIN_STAB         = 0;
   localparam int BIT_SUB_STAB          = 1;

   // Reset values
   localparam logic RST_MAIN_OSC_STOP   = 1'b1;
   localparam logic RST_INT_HS_OSC_STOP = 1'b0;

   // Synchronised pin inputs, one bit each
   localparam int SYN_MAIN_READY = 0;
   localparam int SYN_SUB_READY  = 1;
   localparam int SYN_INT_READY  = 2;
   localparam int SYN_WAKE       = 3;
   localparam int SYN_WIDTH      = 4;

   // Timing
   localparam int CLK_PERIOD_NS     = 100;
   localparam int MAIN_STAB_TIME_US = 1000;
   localparam int SUB_STAB_TIME_US  = 1000;
   localparam int GAP_TIME_NS       = 300;
   localparam int MAIN_STAB_CYCLES  = (MAIN_STAB_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
   localparam int SUB_STAB_CYCLES   = (SUB_STAB_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
   localparam int GAP_CYCLES        = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STAB_CNT_W        = 20;
   localparam logic [2:0] GAP_LAST  = 3'(GAP_CYCLES - 1);

   typedef enum logic [1:0] {
      SRC_INT  = 2'b00,
      SRC_MAIN = 2'b01,
      SRC_SUB  = 2'b10
   } ccs_src_t;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_GAP  = 2'b01,
      ST_HALT = 2'b10,
      ST_STOP = 2'b11
   } ccs_state_t;

endpackage

// file: inc/ccs_sync_if.sv
`timescale 1ns/1ns
interface ccs_sync_if;
   import ccs_pkg::*;
   logic [SYN_WIDTH-1:0] raw;
   logic [SYN_WIDTH-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// file: hdl/ccs_pin_sync.sv
`timescale 1ns/1ns
module ccs_pin_sync
   import ccs_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   ccs_sync_if.sync pins
);

   logic [SYN_WIDTH-1:0] stage1;
   logic [SYN_WIDTH-1:0] stage2;
   logic [SYN_WIDTH-1:0] stage3;
   logic [SYN_WIDTH-1:0] held;

   assign pins.clean = held;

   // A change counts only once the second and third stages agree
   genvar i;
   generate
      for (i = 0; i < SYN_WIDTH; i++) begin : g_bit
         always_ff @(posedge core_clk) begin
            if (reset) begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
               stage3[i] <= 1'b0;
               held[i]   <= 1'b0;
            end else begin
               stage1[i] <= pins.raw[i];
               stage2[i] <= stage1[i];
               stage3[i] <= stage2[i];
               if (stage2[i] == stage3[i]) begin
                  held[i] <= stage3[i];
               end
            end
         end
      end
   endgenerate

endmodule

// file: hdl/ccs_clock_switch.sv
`timescale 1ns/1ns
module ccs_clock_switch
   import ccs_pkg::*;
#(
   parameter int MAIN_STAB_LIMIT = MAIN_STAB_CYCLES,
   parameter int SUB_STAB_LIMIT  = SUB_STAB_CYCLES
)(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output      logic [7:0] reg_rdata,
   input  wire logic       halt_exec,
   input  wire logic       stop_exec,
   input  wire logic       wake_req,
   input  wire logic       main_osc_ready,
   input  wire logic       sub_osc_ready,
   input  wire logic       int_osc_ready,
   output      logic       main_osc_on,
   output      logic       main_osc_ext,
   output      logic       sub_osc_on,
   output      logic       sub_osc_ext,
   output      logic       int_osc_on,
   output      logic [2:0] cpu_clk_en,
   output      logic       halt_active,
   output      logic       stop_active
);

   ccs_sync_if pins ();

   logic                  main_ext_clk_sel;
   logic                  main_osc_mode;
   logic                  sub_ext_clk_sel;
   logic                  sub_osc_mode;
   logic                  main_osc_stop;
   logic                  main_clk_range;
   logic                  range_locked;
   logic                  main_clk_sel;
   logic                  cpu_sub_sel;
   logic                  int_hs_osc_stop;
   logic                  sub_ext_sel;
   logic                  sub_pin_out_en;
   logic [STAB_CNT_W-1:0] main_stab_cnt;
   logic [STAB_CNT_W-1:0] sub_stab_cnt;
   logic [2:0]            gap_cnt;
   ccs_state_t            state;
   ccs_src_t              cur_src;

   assign pins.raw[SYN_MAIN_READY] = main_osc_ready;
   assign pins.raw[SYN_SUB_READY]  = sub_osc_ready;
   assign pins.raw[SYN_INT_READY]  = int_osc_ready;
   assign pins.raw[SYN_WAKE]       = wake_req;

   ccs_pin_sync u_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .pins     (pins.sync)
   );

   // Decode
   wire wr_cms  = reg_wr && (reg_addr == OFS_CLOCK_MODE_SELECT);
   wire wr_moc  = reg_wr && (reg_addr == OFS_MAIN_OSC_CTRL);
   wire wr_mcm  = reg_wr && (reg_addr == OFS_MAIN_CLOCK_MODE);
   wire wr_pcc  = reg_wr && (reg_addr == OFS_PROCESSOR_CLOCK);
   wire wr_iom  = reg_wr && (reg_addr == OFS_INTERNAL_OSC_MODE);
   wire wr_pfc  = reg_wr && (reg_addr == OFS_PORT_FUNCTION);
   // A write of the value already held does not use up the one change
   wire range_take   = wr_mcm && !range_locked &&
                       (reg_wdata[BIT_MAIN_CLK_RANGE] != main_clk_range);

   wire in_stop      = (state == ST_STOP);
   wire main_run     = main_osc_mode && !main_osc_stop && !in_stop;
   wire sub_run      = sub_osc_mode && sub_ext_clk_sel && sub_pin_out_en;
   wire int_run      = !int_hs_osc_stop && !in_stop;
   wire main_rdy_syn = pins.clean[SYN_MAIN_READY];
   wire sub_rdy_syn  = pins.clean[SYN_SUB_READY];
   wire wake_syn     = pins.clean[SYN_WAKE];
   wire int_hs_osc_status = int_run && pins.clean[SYN_INT_READY];
   wire main_stab    = (main_stab_cnt == STAB_CNT_W'(MAIN_STAB_LIMIT));
   wire sub_stab     = (sub_stab_cnt == STAB_CNT_W'(SUB_STAB_LIMIT));
   // An external clock is usable as soon as it is seen, a crystal after its count
   wire main_usable  = main_run && (main_ext_clk_sel ? main_rdy_syn : main_stab);
   wire sub_usable   = sub_run && (sub_ext_sel ? sub_rdy_syn : sub_stab);

   // Unless cpu_sub_sel is set, range low forces the internal clock whatever the main select says
   wire ccs_src_t target_src = cpu_sub_sel ? SRC_SUB :
                               (main_clk_range && main_clk_sel) ? SRC_MAIN : SRC_INT;
   wire target_ready = (target_src == SRC_SUB)  ? sub_usable :
                       (target_src == SRC_MAIN) ? main_usable : int_hs_osc_status;

   // Requests the state machine acts on while running, and the end of the gap
   wire stop_ok      = stop_exec && (cur_src != SRC_SUB);
   wire switch_go    = (target_src != cur_src) && target_ready;
   wire gap_done     = (gap_cnt == GAP_LAST);
   // Every gate shuts outside RUN, so gap, halt and stop give the CPU no edge
   wire [2:0] next_cpu_clk_en = (state == ST_RUN) ? (3'h1 << cur_src) : 3'h0;

   wire cpu_sub_status  = (cur_src == SRC_SUB);
   wire main_clk_status = (cur_src == SRC_MAIN);

   wire [7:0] rd_cms = {main_ext_clk_sel, main_osc_mode, sub_ext_clk_sel,
                        sub_osc_mode, 4'h0};
   wire [7:0] rd_moc = {main_osc_stop, 7'h00};
   wire [7:0] rd_mcm = {5'h00, main_clk_range, main_clk_status, main_clk_sel};
   wire [7:0] rd_pcc = {2'h0, cpu_sub_status, cpu_sub_sel, 4'h0};
   wire [7:0] rd_iom = {int_hs_osc_status, 6'h00, int_hs_osc_stop};
   wire [7:0] rd_pfc = {6'h00, sub_ext_sel, sub_pin_out_en};
   wire [7:0] rd_osc = {6'h00, sub_stab, main_stab};
   wire [7:0] rd_mux = (reg_addr == OFS_CLOCK_MODE_SELECT) ? rd_cms :
                       (reg_addr == OFS_MAIN_OSC_CTRL)     ? rd_moc :
                       (reg_addr == OFS_MAIN_CLOCK_MODE)   ? rd_mcm :
                       (reg_addr == OFS_PROCESSOR_CLOCK)   ? rd_pcc :
                       (reg_addr == OFS_INTERNAL_OSC_MODE) ? rd_iom :
                       (reg_addr == OFS_PORT_FUNCTION)     ? rd_pfc :
                       (reg_addr == OFS_OSC_STAB_STATUS)   ? rd_osc : 8'h00;

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         main_ext_clk_sel <= 1'b0;
         main_osc_mode    <= 1'b0;
         sub_ext_clk_sel  <= 1'b0;
         sub_osc_mode     <= 1'b0;
      end else if (wr_cms) begin
         main_ext_clk_sel <= reg_wdata[BIT_MAIN_EXT_CLK_SEL];
         main_osc_mode    <= reg_wdata[BIT_MAIN_OSC_MODE];
         sub_ext_clk_sel  <= reg_wdata[BIT_SUB_EXT_CLK_SEL];
         sub_osc_mode     <= reg_wdata[BIT_SUB_OSC_MODE];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         main_osc_stop <= RST_MAIN_OSC_STOP;
      end else if (wr_moc) begin
         main_osc_stop <= reg_wdata[BIT_MAIN_OSC_STOP];
      end
   end

   // The range flag takes its first differing write and then locks
   always_ff @(posedge core_clk) begin
      if (reset) begin
         main_clk_range <= 1'b0;
         range_locked   <= 1'b0;
         main_clk_sel   <= 1'b0;
      end else if (wr_mcm) begin
         main_clk_sel <= reg_wdata[BIT_MAIN_CLK_SEL];
         if (range_take) begin
            main_clk_range <= reg_wdata[BIT_MAIN_CLK_RANGE];
            range_locked   <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cpu_sub_sel <= 1'b0;
      end else if (wr_pcc) begin
         cpu_sub_sel <= reg_wdata[BIT_CPU_SUB_SEL];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         int_hs_osc_stop <= RST_INT_HS_OSC_STOP;
      end else if (wr_iom) begin
         int_hs_osc_stop <= reg_wdata[BIT_INT_HS_OSC_STOP];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sub_ext_sel    <= 1'b0;
         sub_pin_out_en <= 1'b0;
      end else if (wr_pfc) begin
         sub_ext_sel    <= reg_wdata[BIT_SUB_EXT_SEL];
         sub_pin_out_en <= reg_wdata[BIT_SUB_PIN_OUT_EN];
      end
   end

   // Stabilisation counts restart whenever the oscillator is turned off
   always_ff @(posedge core_clk) begin
      if (reset || !main_run || !main_rdy_syn) begin
         main_stab_cnt <= '0;
      end else if (!main_stab) begin
         main_stab_cnt <= main_stab_cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || !sub_run || !sub_rdy_syn) begin
         sub_stab_cnt <= '0;
      end else if (!sub_stab) begin
         sub_stab_cnt <= sub_stab_cnt + 1'b1;
      end
   end

   // Clock state machine; the gap keeps every source gate off so no runt
   // pulse reaches the CPU, at the cost of a few dead cycles per switch
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state   <= ST_RUN;
         cur_src <= SRC_INT;
         gap_cnt <= 3'h0;
      end else begin
         case (state)
            ST_RUN: begin
               gap_cnt <= 3'h0;
               if (halt_exec) begin
                  state <= ST_HALT;
               end else if (stop_ok) begin
                  state <= ST_STOP;
               end else if (switch_go) begin
                  state <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (!gap_done) begin
                  gap_cnt <= gap_cnt + 3'h1;
               end else if (target_ready) begin
                  cur_src <= target_src;
                  state   <= ST_RUN;
               end
            end
            ST_HALT: begin
               if (wake_syn) begin
                  state <= ST_RUN;
               end
            end
            ST_STOP: begin
               // Oscillators restart on wake, so the gap waits for them
               if (wake_syn) begin
                  state   <= ST_GAP;
                  gap_cnt <= 3'h0;
               end
            end
            default: begin
               state <= ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cpu_clk_en  <= 3'h0;
         halt_active <= 1'b0;
         stop_active <= 1'b0;
      end else begin
         cpu_clk_en  <= next_cpu_clk_en;
         halt_active <= (state == ST_HALT);
         stop_active <= in_stop;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         main_osc_on  <= 1'b0;
         main_osc_ext <= 1'b0;
         sub_osc_on   <= 1'b0;
         sub_osc_ext  <= 1'b0;
         int_osc_on   <= 1'b0;
      end else begin
         main_osc_on  <= main_run;
         main_osc_ext <= main_ext_clk_sel;
         sub_osc_on   <= sub_run;
         sub_osc_ext  <= sub_ext_sel;
         int_osc_on   <= int_run;
      end
   end

endmodule

// file: sim/ccs_clock_switch_asserts.sv
`timescale 1ns/1ns
module ccs_clock_switch_asserts
   import ccs_pkg::*;
#(
   parameter int MAIN_STAB_LIMIT = MAIN_STAB_CYCLES,
   parameter int SUB_STAB_LIMIT  = SUB_STAB_CYCLES
)(
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       halt_exec,
   input wire logic       stop_exec,
   input wire logic       wake_req,
   input wire logic       main_osc_ready,
   input wire logic       sub_osc_ready,
   input wire logic       int_osc_ready,
   input wire logic       main_osc_on,
   input wire logic       main_osc_ext,
   input wire logic       sub_osc_on,
   input wire logic       sub_osc_ext,
   input wire logic       int_osc_on,
   input wire logic [2:0] cpu_clk_en,
   input wire logic       halt_active,
   input wire logic       stop_active
);
   logic       rd_d;
   logic [7:0] addr_d;
   logic [2:0] en_d;
   logic       range_seen;
   // Range lock is tracked from what software has already read back
   always_ff @(posedge core_clk) begin
      rd_d   <= reg_rd & ~reset;
      addr_d <= reg_addr;
      en_d   <= cpu_clk_en;
      if (reset) begin
         range_seen <= 1'b0;
      end else if (rd_d && addr_d == OFS_MAIN_CLOCK_MODE && reg_rdata[BIT_MAIN_CLK_RANGE]) begin
         range_seen <= 1'b1;
      end
   end
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (reset);
   one_gate_a: assert property ($onehot0(cpu_clk_en))
      else $error("more than one cpu clock gate open");
   no_overlap_a: assert property (($changed(cpu_clk_en) && cpu_clk_en != 3'b000)
      |-> $past(cpu_clk_en) == 3'b000) else $error("clock gate moved without a gap");
   gap_hold_a: assert property (($past(cpu_clk_en) != 3'b000 && cpu_clk_en == 3'b000)
      |=> cpu_clk_en == 3'b000 [*2]) else $error("clock gap too short");
   halt_entry_a: assert property ((halt_exec && cpu_clk_en != 3'b000)
      |-> ##[1:3] halt_active) else $error("halt not entered");
   halt_gate_a: assert property ((halt_active && $past(halt_active))
      |-> cpu_clk_en == 3'b000) else $error("cpu clock runs in halt");
   stop_gate_a: assert property ((stop_active && $past(stop_active))
      |-> cpu_clk_en == 3'b000 && !int_osc_on && !main_osc_on)
      else $error("clock or oscillator runs in stop");
   stop_sub_a: assert property ((stop_exec && cpu_clk_en == 3'b100)
      |=> !stop_active [*3]) else $error("stop taken on subsystem clock");
   sub_status_a: assert property ((reg_rd && reg_addr == OFS_PROCESSOR_CLOCK
      && cpu_clk_en != 3'b000) |=> reg_rdata[BIT_CPU_SUB_STATUS] == en_d[2])
      else $error("subsystem status disagrees with clock gate");
   main_status_a: assert property ((reg_rd && reg_addr == OFS_MAIN_CLOCK_MODE
      && cpu_clk_en[1:0] != 2'b00) |=> reg_rdata[BIT_MAIN_CLK_STATUS] == en_d[1])
      else $error("main status disagrees with clock gate");
   range_lock_a: assert property ((rd_d && addr_d == OFS_MAIN_CLOCK_MODE && range_seen)
      |-> reg_rdata[BIT_MAIN_CLK_RANGE]) else $error("range flag changed twice");
endmodule
bind ccs_clock_switch ccs_clock_switch_asserts #(
   .MAIN_STAB_LIMIT(MAIN_STAB_LIMIT), .SUB_STAB_LIMIT(SUB_STAB_LIMIT)
) ccs_clock_switch_asserts_inst (
   .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
   .stop_exec(stop_exec), .wake_req(wake_req), .main_osc_ready(main_osc_ready),
   .sub_osc_ready(sub_osc_ready), .int_osc_ready(int_osc_ready), .main_osc_on(main_osc_on),
   .main_osc_ext(main_osc_ext), .sub_osc_on(sub_osc_on), .sub_osc_ext(sub_osc_ext),
   .int_osc_on(int_osc_on), .cpu_clk_en(cpu_clk_en), .halt_active(halt_active),
   .stop_active(stop_active)
);

// file: sim/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module testbench;
   import ccs_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset    = 1'b1;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, halt_exec = 1'b0, stop_exec = 1'b0;
   logic        wake_req = 1'b0, main_osc_ready = 1'b0, sub_osc_ready = 1'b0;
   logic        int_osc_ready = 1'b1;
   logic        main_osc_on, main_osc_ext, sub_osc_on, sub_osc_ext, int_osc_on;
   logic        halt_active, stop_active, rd_d = 1'b0;
   logic [2:0]  cpu_clk_en;
   logic [15:0] rd_q[$];
   int          miscompares = 0, checks = 0, cycles = 0;
   always #50 core_clk = ~core_clk;
   // Short stabilisation count keeps the crystal waits brief
   ccs_clock_switch #(.MAIN_STAB_LIMIT(8), .SUB_STAB_LIMIT(8)) ccs_clock_switch_inst (
      .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
      .stop_exec(stop_exec), .wake_req(wake_req), .main_osc_ready(main_osc_ready),
      .sub_osc_ready(sub_osc_ready), .int_osc_ready(int_osc_ready),
      .main_osc_on(main_osc_on), .main_osc_ext(main_osc_ext), .sub_osc_on(sub_osc_on),
      .sub_osc_ext(sub_osc_ext), .int_osc_on(int_osc_on), .cpu_clk_en(cpu_clk_en),
      .halt_active(halt_active), .stop_active(stop_active));
   task print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Read data is only valid in the cycle after the strobe
   always @(posedge core_clk) begin
      logic [15:0] n;
      rd_d <= reg_rd;
      if (rd_d && rd_q.size() > 0) begin
         n = rd_q.pop_front();
         `CHK($sformatf("reg %0h", n[15:8]), n[7:0], reg_rdata)
      end
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict;
      end
   end
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rd_q.push_back({a, e});
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   task wait_en(input logic [2:0] e, input string n);
      for (int i = 0; i < 300 && cpu_clk_en !== e; i++) @(posedge core_clk);
      `CHK(n, e, cpu_clk_en)
   endtask
   task halt_cycle(input logic [2:0] e);
      halt_exec <= 1'b1;
      cyc(1);
      halt_exec <= 1'b0;
      cyc(3);
      `CHK("halt gate", 4'b1000, {halt_active, cpu_clk_en})
      wake_req <= 1'b1;
      wait_en(e, "wake gate");
      wake_req <= 1'b0;
      cyc(6);
   endtask
   initial begin
      logic [7:0] a, r;
      a = 8'($urandom(46));
      cyc(8);
      reset <= 1'b0;
      rd(OFS_CLOCK_MODE_SELECT, 8'h00);
      rd(OFS_MAIN_OSC_CTRL, 8'h80);
      rd(OFS_MAIN_CLOCK_MODE, 8'h00);
      rd(OFS_PROCESSOR_CLOCK, 8'h00);
      rd(OFS_INTERNAL_OSC_MODE, 8'h80);
      a = 8'h07 + 8'($urandom_range(0, 248));
      r = 8'($urandom);
      wr(a, r);
      rd(a, 8'h00);
      wr(OFS_PORT_FUNCTION, r);
      rd(OFS_PORT_FUNCTION, {6'h00, r[1:0]});
      wr(OFS_PORT_FUNCTION, 8'h00);
      `CHK("reset gate", 3'b001, cpu_clk_en)
      halt_cycle(3'b001);
      $display("test reset values done");
      wr(OFS_CLOCK_MODE_SELECT, 8'hc0);
      wr(OFS_MAIN_OSC_CTRL, 8'h00);
      main_osc_ready <= 1'b1;
      wr(OFS_MAIN_CLOCK_MODE, 8'h05);
      wait_en(3'b010, "main gate");
      `CHK("main pins", 2'b11, {main_osc_on, main_osc_ext})
      rd(OFS_MAIN_CLOCK_MODE, 8'h07);
      wr(OFS_MAIN_CLOCK_MODE, 8'h03);
      rd(OFS_MAIN_CLOCK_MODE, 8'h07);
      cyc(10);
      `CHK("range lock gate", 3'b010, cpu_clk_en)
      halt_cycle(3'b010);
      $display("test main external done");
      wr(OFS_PORT_FUNCTION, 8'h03);
      wr(OFS_CLOCK_MODE_SELECT, 8'hf0);
      sub_osc_ready <= 1'b1;
      wr(OFS_PROCESSOR_CLOCK, 8'h10);
      wait_en(3'b100, "sub gate");
      rd(OFS_PROCESSOR_CLOCK, 8'h30);
      `CHK("sub pins", 2'b11, {sub_osc_on, sub_osc_ext})
      stop_exec <= 1'b1;
      cyc(1);
      stop_exec <= 1'b0;
      cyc(5);
      `CHK("stop on sub", 4'b0100, {stop_active, cpu_clk_en})
      halt_cycle(3'b100);
      $display("test sub external done");
      wr(OFS_INTERNAL_OSC_MODE, 8'h00);
      rd(OFS_INTERNAL_OSC_MODE, 8'h80);
      wr(OFS_MAIN_CLOCK_MODE, 8'h04);
      wr(OFS_PROCESSOR_CLOCK, 8'h00);
      wait_en(3'b001, "back to internal");
      rd(OFS_PROCESSOR_CLOCK, 8'h00);
      stop_exec <= 1'b1;
      cyc(1);
      stop_exec <= 1'b0;
      cyc(3);
      `CHK("stop state", 6'h20, {stop_active, int_osc_on, main_osc_on, cpu_clk_en})
      int_osc_ready <= 1'b0;
      wake_req <= 1'b1;
      cyc(12);
      `CHK("wait for internal", 3'b000, cpu_clk_en)
      int_osc_ready <= 1'b1;
      wait_en(3'b001, "stop wake");
      wake_req <= 1'b0;
      cyc(6);
      $display("test internal and stop done");
      wr(OFS_PROCESSOR_CLOCK, 8'h10);
      wait_en(3'b100, "sub again");
      wr(OFS_MAIN_OSC_CTRL, 8'h80);
      main_osc_ready <= 1'b0;
      wr(OFS_CLOCK_MODE_SELECT, 8'h70);
      wr(OFS_MAIN_OSC_CTRL, 8'h00);
      cyc(30);
      `CHK("crystal not stable", 3'b100, cpu_clk_en)
      rd(OFS_OSC_STAB_STATUS, 8'h02);
      main_osc_ready <= 1'b1;
      cyc(20);
      rd(OFS_OSC_STAB_STATUS, 8'h03);
      wr(OFS_MAIN_CLOCK_MODE, 8'h05);
      wr(OFS_PROCESSOR_CLOCK, 8'h00);
      wait_en(3'b010, "crystal gate");
      wr(OFS_MAIN_CLOCK_MODE, 8'h04);
      wait_en(3'b001, "main to internal");
      sub_osc_ready <= 1'b0;
      wr(OFS_PORT_FUNCTION, 8'h01);
      cyc(8);
      rd(OFS_OSC_STAB_STATUS, 8'h01);
      sub_osc_ready <= 1'b1;
      cyc(20);
      rd(OFS_OSC_STAB_STATUS, 8'h03);
      wr(OFS_PROCESSOR_CLOCK, 8'h10);
      wait_en(3'b100, "sub crystal gate");
      `CHK("sub crystal pins", 2'b10, {sub_osc_on, sub_osc_ext})
      wr(OFS_PROCESSOR_CLOCK, 8'h00);
      wait_en(3'b001, "sub to internal");
      $display("test crystal done");
      reset <= 1'b1;
      cyc(8);
      reset <= 1'b0;
      wr(OFS_MAIN_CLOCK_MODE, 8'h04);
      rd(OFS_MAIN_CLOCK_MODE, 8'h04);
      cyc(3);
      $display("test second reset done");
      print_verdict;
   end
endmodule
